//--- hdl/completion_record_writer.sv
// Purpose: writes 32-byte completion records for finished descriptors
// Assumes: APB register access, one record in flight at a time
// Notes:   status word goes out last so it never precedes its fields
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "crw_map.svh"
module completion_record_writer #(
  parameter logic [5:0] INV_FLAGS_CODE = 6'h10,
  parameter int         CNT_W          = 16
) (
  input  wire logic                pclk,        // system clock
  input  wire logic                presetn,     // async reset, low
  input  wire logic                psel,        // apb select
  input  wire logic                penable,     // apb access phase
  input  wire logic                pwrite,      // apb write
  input  wire logic [7:0]          paddr,       // apb byte address
  input  wire logic [31:0]         pwdata,      // apb write data
  output logic [31:0]              prdata,      // apb read data
  output logic                     pready,      // apb ready
  output logic                     pslverr,     // apb error
  input  wire logic                req_valid,   // completion offered
  output logic                     req_ready,   // completion taken
  input  crw_pkg::cmp_req_type     req,         // completion content
  input  wire logic                prior_done,  // earlier batch entries done
  output logic                     mw_valid,    // memory write valid
  input  wire logic                mw_ready,    // memory write accepted
  output crw_pkg::mem_wr_type      mw,          // memory write beat
  output logic                     irq_req      // completion interrupt request
);
  import crw_pkg::*;

  // counters wider than a register word cannot be read back
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_cnt_w_check
    $error("CNT_W out of range");
  end

  wr_state_type       state_q;
  cmp_req_type        req_q;
  logic [1:0]         beat_q;
  logic [3:0][63:0]   words;
  logic               en_q;
  logic [3:1]         sticky_q;
  logic [CNT_W-1:0]   wrcnt_q;
  logic [CNT_W-1:0]   skipcnt_q;
  logic               take;
  logic               fence_hold;
  logic               need_rec;
  logic               misal;
  logic               zero_code;
  logic               go_write;
  logic               drop;
  logic               beat_done;
  logic               rec_done;
  logic               apb_setup;
  logic               apb_wr;
  logic               mapped;

  crw_record_packer #(
    .INV_FLAGS_CODE (INV_FLAGS_CODE)
  ) u_packer (
    .req   (req_q),
    .words (words)
  );

  assign take      = req_valid && req_ready;
  assign req_ready = en_q && (state_q == ST_IDLE);
  // fenced entry in a batch holds for earlier ones
  assign fence_hold = req_q.fence && req_q.in_batch && !prior_done;
  // success-class codes skip unless record requested
  assign need_rec  = req_q.addr_valid && (req_q.want_record || !is_success_class(req_q.status));
  // misaligned record address refused, never half written
  assign misal     = req_q.rec_addr[`CRW_REC_ALIGN-1:0] != 5'h00;
  // a zero code would look like an unwritten record
  assign zero_code = req_q.status == `CRW_ST_NONE;
  assign go_write  = (state_q == ST_FENCE) && !fence_hold && need_rec && !misal && !zero_code;
  assign drop      = (state_q == ST_FENCE) && !fence_hold && !go_write;
  assign beat_done = mw_valid && mw_ready;
  assign rec_done  = beat_done && (beat_q == `CRW_BEAT_FIRST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:  state_q <= take ? ST_FENCE : ST_IDLE;
        ST_FENCE: state_q <= go_write ? ST_BEAT : (drop ? ST_IDLE : ST_FENCE);
        ST_BEAT:  state_q <= rec_done ? ST_IDLE : ST_BEAT;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_q <= '0;
    else if (take)
      req_q <= req;
  end

  // highest word first, status word last
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beat_q   <= `CRW_BEAT_LAST;
      mw_valid <= 1'b0;
      mw       <= '0;
    end
    else if (go_write)
    begin
      beat_q   <= `CRW_BEAT_LAST;
      mw_valid <= 1'b1;
      mw.addr  <= req_q.rec_addr + (64'(`CRW_BEAT_LAST) << `CRW_BEAT_SHIFT);
      mw.data  <= words[`CRW_BEAT_LAST];
      mw.last  <= 1'b0;
    end
    else if (beat_done)
    begin
      beat_q   <= beat_q - 2'h1;
      mw_valid <= !rec_done;
      mw.addr  <= req_q.rec_addr + (64'(beat_q - 2'h1) << `CRW_BEAT_SHIFT);
      mw.data  <= words[beat_q - 2'h1];
      mw.last  <= (beat_q == 2'h1);
    end
  end

  // no-op gives its interrupt once resolved
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_req <= 1'b0;
    else
      irq_req <= (rec_done || drop) && req_q.want_irq;
  end

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && pready;
  assign pready    = 1'b1;
  assign mapped    = (paddr == `CRW_REG_CTRL) || (paddr == `CRW_REG_STAT) ||
                     (paddr == `CRW_REG_WRCNT) || (paddr == `CRW_REG_SKIPCNT);
  assign pslverr   = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_q <= `CRW_CTRL_RST;
    else if (apb_wr && paddr == `CRW_REG_CTRL)
      en_q <= pwdata[`CRW_CTRL_EN];
  end

  // refusals are sticky; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sticky_q <= 3'h0;
    else
    begin
      if (apb_wr && paddr == `CRW_REG_STAT)
        sticky_q <= sticky_q & ~pwdata[`CRW_STAT_NOADDR:`CRW_STAT_MISAL] |
                    {drop && !req_q.addr_valid, drop && zero_code, drop && misal};
      else
        sticky_q <= sticky_q | {drop && !req_q.addr_valid, drop && zero_code, drop && misal};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wrcnt_q   <= '0;
      skipcnt_q <= '0;
    end
    else
    begin
      if (rec_done)
        wrcnt_q <= wrcnt_q + 1'b1;
      if (drop)
        skipcnt_q <= skipcnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
    begin
      case (paddr)
        `CRW_REG_CTRL:    prdata <= {31'h0000_0000, en_q};
        `CRW_REG_STAT:    prdata <= {28'h000_0000, sticky_q, state_q != ST_IDLE};
        `CRW_REG_WRCNT:   prdata <= 32'(wrcnt_q);
        `CRW_REG_SKIPCNT: prdata <= 32'(skipcnt_q);
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  logic [2:0] beats_seen_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      beats_seen_q <= 3'h0;
    else if (rec_done)
      beats_seen_q <= 3'h0;
    else if (beat_done)
      beats_seen_q <= beats_seen_q + 3'h1;
  end

  property p_rec_len;
    @(posedge pclk) disable iff (!presetn) rec_done |-> beats_seen_q == 3'h3;
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("record not four beats");

  property p_nonzero;
    @(posedge pclk) disable iff (!presetn) mw_valid && mw.last |-> mw.data[5:0] != 6'h00;
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("zero status written");

  property p_bit6;
    @(posedge pclk) disable iff (!presetn) mw_valid && mw.last |-> !mw.data[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("status bit 6 set");

  property p_dir;
    @(posedge pclk) disable iff (!presetn)
      mw_valid && mw.last |-> mw.data[7] == (is_xlat_fault(req_q.status) && req_q.fault_write);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");

  property p_full_zero;
    @(posedge pclk) disable iff (!presetn)
      mw_valid && mw.last && !req_q.partial |-> mw.data[63:32] == 32'h0000_0000;
  endproperty
  a_full_zero: assert property (p_full_zero) else $error("count nonzero on completion");

  property p_status_last;
    @(posedge pclk) disable iff (!presetn)
      mw_valid |-> (mw.last == (mw.addr[4:0] == 5'h00)) && (!mw.last || beats_seen_q == 3'h3);
  endproperty
  a_status_last: assert property (p_status_last) else $error("status word not last");

  property p_skip;
    @(posedge pclk) disable iff (!presetn)
      state_q == ST_FENCE && !fence_hold && !req_q.want_record && is_success_class(req_q.status)
      |=> state_q == ST_IDLE && !mw_valid;
  endproperty
  a_skip: assert property (p_skip) else $error("success record written unasked");

  property p_fence;
    @(posedge pclk) disable iff (!presetn)
      state_q == ST_FENCE && req_q.fence && req_q.in_batch && !prior_done |=> !mw_valid;
  endproperty
  a_fence: assert property (p_fence) else $error("fence overtaken");

  property p_invmask;
    @(posedge pclk) disable iff (!presetn)
      mw_valid && beat_q == 2'h2 && req_q.status == INV_FLAGS_CODE |-> mw.data[23:0] != 24'h000000;
  endproperty
  a_invmask: assert property (p_invmask) else $error("empty invalid mask");

  c_write: cover property (@(posedge pclk) disable iff (!presetn) rec_done);
  c_drop:  cover property (@(posedge pclk) disable iff (!presetn) drop);
  c_fence: cover property (@(posedge pclk) disable iff (!presetn) fence_hold ##1 go_write);
  c_stall: cover property (@(posedge pclk) disable iff (!presetn) mw_valid && !mw_ready);
endmodule

//--- hdl/crw_map.svh
// Purpose: offsets, field positions and codes of the completion record writer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef CRW_MAP_SVH
`define CRW_MAP_SVH
// register byte addresses
`define CRW_REG_CTRL     8'h00
`define CRW_REG_STAT     8'h04
`define CRW_REG_WRCNT    8'h08
`define CRW_REG_SKIPCNT  8'h0C
// control and status bits
`define CRW_CTRL_EN      0
`define CRW_STAT_BUSY    0
`define CRW_STAT_MISAL   1
`define CRW_STAT_ZERO    2
`define CRW_STAT_NOADDR  3
`define CRW_CTRL_RST     1'h1
// record layout
`define CRW_REC_BEATS    4
`define CRW_REC_ALIGN    5
`define CRW_BEAT_SHIFT   3
`define CRW_BEAT_LAST    2'h3
`define CRW_BEAT_FIRST   2'h0
// status codes
`define CRW_ST_SUCCESS   6'h01
`define CRW_ST_SUCC_B    6'h02
`define CRW_ST_SUCC_C    6'h05
`define CRW_ST_XLAT_A    6'h03
`define CRW_ST_XLAT_B    6'h04
`define CRW_ST_XLAT_C    6'h06
`define CRW_ST_XLAT_D    6'h1A
`define CRW_ST_NONE      6'h00
`define CRW_INV_FALLBACK 24'h000001
`endif

//--- hdl/crw_pkg.sv
// Purpose: types and decode functions of the completion record writer
// Assumes: crw_map.svh supplies the codes
// Notes:   shared by the writer and its record packer
`include "crw_map.svh"
package crw_pkg;
  typedef struct packed {
    logic [63:0] rec_addr;
    logic [5:0]  status;
    logic        fault_write;
    logic [7:0]  result;
    logic        result_valid;
    logic        partial;
    logic [31:0] bytes_done;
    logic [63:0] fault_addr;
    logic [23:0] inv_mask;
    logic [31:0] dest_bytes;
    logic        dest_valid;
    logic        is_noop;
    logic        want_record;
    logic        addr_valid;
    logic        want_irq;
    logic        fence;
    logic        in_batch;
  } cmp_req_type;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic        last;
  } mem_wr_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FENCE = 3'b010,
    ST_BEAT  = 3'b100
  } wr_state_type;

  function automatic logic is_xlat_fault(input logic [5:0] code);
    is_xlat_fault = (code == `CRW_ST_XLAT_A) || (code == `CRW_ST_XLAT_B) ||
                    (code == `CRW_ST_XLAT_C) || (code == `CRW_ST_XLAT_D);
  endfunction

  function automatic logic is_success_class(input logic [5:0] code);
    is_success_class = (code == `CRW_ST_SUCCESS) || (code == `CRW_ST_SUCC_B) ||
                       (code == `CRW_ST_SUCC_C);
  endfunction
endpackage

//--- hdl/crw_record_packer.sv
// Purpose: lays one completion out as four 64-bit words of a 32-byte record
// Assumes: request is held stable by the caller
// Notes:   purely combinational
`timescale 1ns/1ns
`include "crw_map.svh"
module crw_record_packer #(
  parameter logic [5:0] INV_FLAGS_CODE = 6'h10
) (
  input  crw_pkg::cmp_req_type     req,   // completion to encode
  output logic [3:0][63:0]         words  // record words, index = byte offset / 8
);
  import crw_pkg::*;
  logic [7:0]  status_byte;
  logic [7:0]  result_byte;
  logic [31:0] done_cnt;
  logic [23:0] mask_field;

  always_comb
  begin
    // direction bit only for translation faults
    status_byte = {is_xlat_fault(req.status) & req.fault_write, 1'b0, req.status};
    result_byte = (req.result_valid && !req.is_noop) ? req.result : 8'h00;
    // count on partial unless no-op, zero when complete or no-op
    done_cnt = (req.partial && !req.is_noop) ? req.bytes_done : 32'h0000_0000;
    // invalid-flag mask, never empty, else op data
    if (req.status == INV_FLAGS_CODE)
    begin
      mask_field = (req.inv_mask == 24'h000000) ? `CRW_INV_FALLBACK : req.inv_mask;
    end
    else
    begin
      mask_field = req.is_noop ? 24'h000000 : req.inv_mask;
    end
    // bit 6 left zero, code in 5:0
    words[0] = {done_cnt, 16'h0000, result_byte, status_byte};
    words[1] = req.partial ? req.fault_addr : 64'h0000_0000_0000_0000;
    words[2] = {40'h00_0000_0000, mask_field};
    // output length where count cannot give it
    words[3] = req.dest_valid ? {32'h0000_0000, req.dest_bytes} : 64'h0000_0000_0000_0000;
  end
endmodule

//--- verif/host_mem_model.sv
// Purpose: host memory taking completion record beats
// Assumes: one record in flight, beats of 64 bits
// Notes:   ready stalls at random when slow is set
`timescale 1ns/1ns
module host_mem_model (
  input  wire logic           pclk,     // clock
  input  wire logic           presetn,  // reset, low
  input  wire logic           slow,     // random stalls
  input  wire logic           clr,      // software wipes record
  input  wire logic           mw_valid, // beat offered
  output logic                mw_ready, // beat taken
  input  crw_pkg::mem_wr_type mw,       // beat
  output logic [3:0][63:0]    words,    // record image
  output logic [63:0]         base,     // address of last record
  output logic [7:0]          recs,     // records finished
  output logic                order_ok  // status beat came last
);
  import crw_pkg::*;
  logic [2:0] nbeat;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mw_ready <= 1'b0;
      nbeat <= 3'h0;
      recs <= 8'h00;
      order_ok <= 1'b1;
      words <= '0;
      base <= 64'h0;
    end
    else
    begin
      mw_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
      if (clr)
        words <= '0;
      else if (mw_valid && mw_ready)
      begin
        words[mw.addr[4:3]] <= mw.data;
        nbeat <= mw.last ? 3'h0 : nbeat + 3'h1;
        if (mw.last)
        begin
          recs <= recs + 8'h01;
          base <= mw.addr;
          if (nbeat != 3'h3 || mw.addr[4:3] != 2'h0)
            order_ok <= 1'b0;
        end
      end
    end
  end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench of the completion record writer
// Assumes: zero-wait APB, host memory model on the beat port
// Notes:   random record contents, fixed seed
`timescale 1ns/1ns
module tb;
  import crw_pkg::*;
  localparam logic [5:0] INV = 6'h10;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, r;
  logic               req_valid, req_ready, prior_done, mw_valid, mw_ready, irq_req;
  logic               slow, clr, order_ok, e;
  cmp_req_type        req, c;
  mem_wr_type         mw;
  logic [3:0][63:0]   words;
  logic [63:0]        base;
  logic [7:0]         recs;
  logic [5:0]         codes [9] = '{6'h01, 6'h02, 6'h05, 6'h03, 6'h04, 6'h06, 6'h1A, INV, 6'h08};
  int                 n_errors, samples_checked, n_irq, ewr, es;

  completion_record_writer #(.INV_FLAGS_CODE(INV), .CNT_W(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .prior_done(prior_done), .mw_valid(mw_valid), .mw_ready(mw_ready), .mw(mw), .irq_req(irq_req));
  host_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .clr(clr), .mw_valid(mw_valid),
    .mw_ready(mw_ready), .mw(mw), .words(words), .base(base), .recs(recs), .order_ok(order_ok));

  always #2 pclk = ~pclk;
  always @(posedge pclk)
    if (irq_req === 1'b1)
      n_irq++;

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("reg", r, exp);
  endtask

  function automatic logic skip(input cmp_req_type c);
    skip = (c.status inside {6'h01, 6'h02, 6'h05} && !c.want_record) || !c.addr_valid ||
           c.rec_addr[4:0] != 5'h00 || c.status == 6'h00;
  endfunction

  function automatic logic [63:0] ew(input cmp_req_type c, input int i);
    logic [23:0] m;
    m = c.is_noop ? 24'h0 : c.inv_mask;
    if (c.status == INV && m == 24'h0)
      m = 24'h000001;
    case (i)
      0: ew = {(c.partial && !c.is_noop) ? c.bytes_done : 32'h0, 16'h0,
               (c.result_valid && !c.is_noop) ? c.result : 8'h00,
               c.fault_write && (c.status inside {6'h03, 6'h04, 6'h06, 6'h1A}), 1'b0, c.status};
      1: ew = c.partial ? c.fault_addr : 64'h0;
      2: ew = {40'h0, m};
      default: ew = c.dest_valid ? {32'h0, c.dest_bytes} : 64'h0;
    endcase
  endfunction

  function automatic cmp_req_type rnd(input logic [5:0] st);
    logic [255:0] b;
    b = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    rnd = b[$bits(cmp_req_type)-1:0];
    rnd.status = st;
    rnd.rec_addr[4:0] = 5'h00;
    rnd.addr_valid = 1'b1;
    rnd.want_record = 1'b1;
    rnd.fence = 1'b0;
    rnd.is_noop = 1'b0;
  endfunction

  task automatic run(input cmp_req_type c, input int hold);
    int n0, i0, k;
    logic drop;
    drop = skip(c);
    n0 = recs;
    i0 = n_irq;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    req <= c;
    req_valid <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (hold)
    begin
      @(posedge pclk);
      chk("fence_wait", mw_valid, 64'h0);
    end
    prior_done <= 1'b1;
    k = 0;
    while (!drop && recs == n0)
    begin
      @(posedge pclk);
      k++;
    end
    repeat (drop ? 12 : 3) @(posedge pclk);
    chk("records", recs, 8'(n0 + (drop ? 0 : 1)));
    chk("irq", n_irq, i0 + c.want_irq);
    if (!drop)
    begin
      for (k = 0; k < 4; k++)
        chk("word", words[k], ew(c, k));
      chk("base", base, c.rec_addr);
      chk("order", order_ok, 64'h1);
      ewr++;
    end
    else
      es++;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req = '0;
    req_valid = 1'b0;
    prior_done = 1'b1;
    slow = 1'b0;
    clr = 1'b0;
    void'($urandom(1696));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", e, 64'h1);
    chk("unmapped_data", r, 64'h0);
    for (int i = 0; i < 9; i++)
      for (int v = 0; v < 3; v++)
      begin
        c = rnd(codes[i]);
        c.want_record = (v != 1);
        if (v == 2)
          c.inv_mask = 24'h0;
        slow <= (v == 1);
        run(c, 0);
      end
    c = rnd(6'h01);
    {c.is_noop, c.fence, c.in_batch, c.want_irq, c.partial, c.dest_valid} = 6'b111100;
    prior_done <= 1'b0;
    run(c, 6);
    c = rnd(6'h03);
    c.status = 6'h00;
    run(c, 0);
    c = rnd(6'h04);
    c.rec_addr[4:0] = 5'h08;
    run(c, 0);
    c = rnd(6'h08);
    c.addr_valid = 1'b0;
    run(c, 0);
    rd(8'h04, 32'hE);
    apb(1'b1, 8'h04, 32'hE);
    rd(8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    @(posedge pclk);
    chk("ready_off", req_ready, 64'h0);
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h08, 32'(ewr));
    rd(8'h0C, 32'(es));
    test_done();
  end

  initial
  begin
    #40000;
    n_errors++;
    test_done();
  end
endmodule
